/* File: rtl/ccp_pkg.sv */
// Package of constants and carrier types for the capture/compare/PWM unit
// Behaviour
// [RQ1] Writing mode 0000 switches the unit off and resets prescaler and output latch.
// [RQ2] Modes 0100..0111 capture on falling, rising, 4th rising, 16th rising edge.
// [RQ3] Mode 1000 sets, 1001 clears the output on match; both set the flag.
// [RQ4] Mode 1010 sets the flag only; request leaves only when enabled.
// [RQ5] Mode 1011 sets the flag and raises the special trigger.
// [RQ6] Modes 11xx are PWM; control bits 5:4 are the duty's two low bits.
// [RQ7] Each capture event copies the 16-bit timer into the data pair and flags.
// [RQ8] Software clears the flag; hardware never clears it.
// [RQ9] A new capture overwrites unread data; no overrun is kept.
// [RQ10] Prescaler counter is held clear when off or outside capture modes.
// [RQ11] Switching between capture prescale settings keeps the prescaler count.
// [RQ12] Software should write zero before choosing a new prescale setting.
// [RQ13] Software should keep the enable clear across mode changes, then clear flag.
// [RQ14] Capture watches the pin level, so driving the pin can capture.
// [RQ15] Compare runs continuously; pin action and flag follow the same match.
// [RQ16] Clearing control forces the unit's own output latch low.
// [RQ17] Trigger follows the match at once; timer resets on its next tick.
// [RQ18] The trigger starts a conversion only while the converter is enabled.
// [RQ19] Rewriting the pair before the timer tick removes the match and reset.
// [RQ20] Software runs the 16-bit timer in a synchronous mode.
// [RQ21] Capture and compare use the 16-bit timer; PWM uses the 8-bit timer.
// [RQ22] Software sets pin direction: input for capture, output otherwise.
// [RQ23] At period end the output is set unless duty is zero; duty is reloaded.
// [RQ24] Output clears when buffered 10-bit duty equals timer with two low bits.
// [RQ25] In PWM the high data register is read-only and holds active duty.
// [RQ26] A duty above the period never clears the output in that period.
// [RQ27] The capture pin is synchronised before edge detection.
package ccp_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_DATA_LOW = 6'h15;
  localparam logic [5:0] IDX_DATA_HIGH = 6'h16;
  localparam logic [5:0] IDX_MODE_CONTROL = 6'h17;
  localparam logic [5:0] IDX_IRQ_CONTROL = 6'h18;
  localparam logic [7:0] ADDR_DATA_LOW = {IDX_DATA_LOW, 2'b00};
  localparam logic [7:0] ADDR_DATA_HIGH = {IDX_DATA_HIGH, 2'b00};
  localparam logic [7:0] ADDR_MODE_CONTROL = {IDX_MODE_CONTROL, 2'b00};
  localparam logic [7:0] ADDR_IRQ_CONTROL = {IDX_IRQ_CONTROL, 2'b00};

  localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Fields of the interrupt control register
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_ENABLE_BIT = 1;
  localparam int OUT_LATCH_BIT = 2;

  // Mode field encodings
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hb;
  localparam logic [1:0] GROUP_CAPTURE = 2'h1;
  localparam logic [1:0] GROUP_COMPARE = 2'h2;
  localparam logic [1:0] GROUP_PWM = 2'h3;

  // Prescaler count values that complete an event
  localparam logic [3:0] PRESCALE4_LAST = 4'h3;
  localparam logic [3:0] PRESCALE16_LAST = 4'hf;

  typedef struct packed {
    logic [1:0] unused;
    logic duty_bit_one;
    logic duty_bit_zero;
    logic [3:0] mode;
  } ccp_ctrl_t;

  // 8-bit period timer as seen by the PWM logic
  typedef struct packed {
    logic [7:0] count;
    logic [1:0] sub;
    logic tick;
    logic [7:0] limit;
  } ccp_pwm_timer_t;

endpackage

/* File: rtl/ccp_unit.sv */
// Capture/compare/PWM unit with an APB register slave
module ccp_unit (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ccp_pkg::ADDR_W-1:0] PADDR,
  input wire logic [ccp_pkg::DATA_W-1:0] PWDATA,
  output logic [ccp_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [15:0] SIXTEEN_BIT_TIMER,
  input wire ccp_pkg::ccp_pwm_timer_t EIGHT_BIT_PERIOD_TIMER,
  input wire logic UNIT_IO_PIN_IN,
  input wire logic ADC_ENABLE,
  output logic UNIT_IO_PIN_OUT,
  output logic SPECIAL_TRIGGER,
  output logic ADC_START,
  output logic UNIT_IRQ
);
  import ccp_pkg::*;

  ccp_ctrl_t ctrl;
  logic [7:0] data_low;
  logic [7:0] data_high;
  logic [1:0] duty_latch;
  logic unit_irq_flag;
  logic unit_irq_enable;
  logic [3:0] presc;
  logic pin_s1;
  logic pin_s2;
  logic pin_s3;
  logic cmp_eq_q;
  logic out_latch;
  logic ready;
  logic [DATA_W-1:0] rdata;
  logic slverr;
  logic trig;
  logic adc_go;
  logic irq_out;

  logic setup_wait;
  logic access;
  logic wr;
  logic hit_low;
  logic hit_high;
  logic hit_ctrl;
  logic hit_irq;
  logic hit_any;
  logic ctrl_off_wr;
  logic is_cap;
  logic is_cmp;
  logic is_pwm;
  logic rise;
  logic fall;
  logic cap_evt;
  logic cmp_eq;
  logic cmp_evt;
  logic period_end;
  logic pwm_clear;
  logic [9:0] next_duty;
  logic [DATA_W-1:0] next_rdata;
  logic mode_set;
  logic mode_clear;
  logic mode_trig;
  logic cap_take;
  logic flag_set;
  logic flag_clear;
  logic low_wr;
  logic high_wr;
  logic irq_wr;
  logic next_out_latch;
  logic next_trig;
  logic next_adc_go;
  logic next_flag;
  logic [7:0] next_data_low;
  logic [7:0] next_data_high;
  logic [3:0] next_presc;
  logic [1:0] next_duty_latch;

  // Bus decode
  always_comb begin
    setup_wait = PSEL & PENABLE & ~ready;
    access = PSEL & PENABLE & ready;
    wr = access & PWRITE;
    hit_low = (PADDR == ADDR_DATA_LOW);
    hit_high = (PADDR == ADDR_DATA_HIGH);
    hit_ctrl = (PADDR == ADDR_MODE_CONTROL);
    hit_irq = (PADDR == ADDR_IRQ_CONTROL);
    hit_any = hit_low | hit_high | hit_ctrl | hit_irq;
    ctrl_off_wr = wr & hit_ctrl & (PWDATA[3:0] == MODE_OFF);
  end

  // Write strobes and per-mode actions
  always_comb begin
    low_wr = wr & hit_low;
    high_wr = wr & hit_high & ~is_pwm; // see [RQ25]
    irq_wr = wr & hit_irq;
    mode_set = (ctrl.mode == MODE_CMP_SET);
    mode_clear = (ctrl.mode == MODE_CMP_CLEAR);
    mode_trig = (ctrl.mode == MODE_CMP_TRIG);
    cap_take = is_cap & cap_evt; // see [RQ7] [RQ9]
    // Flag-only mode shares the flag path but never touches the pin
    flag_set = cap_take | cmp_evt; // see [RQ3] [RQ4] [RQ5]
    flag_clear = irq_wr & PWDATA[IRQ_FLAG_BIT]; // see [RQ8]
    next_trig = cmp_eq & mode_trig; // see [RQ5] [RQ17] [RQ19]
    next_adc_go = cmp_evt & mode_trig & ADC_ENABLE; // see [RQ18]
  end

  // Mode groups and events
  always_comb begin
    is_cap = (ctrl.mode[3:2] == GROUP_CAPTURE);
    is_cmp = (ctrl.mode[3:2] == GROUP_COMPARE);
    is_pwm = (ctrl.mode[3:2] == GROUP_PWM); // see [RQ6]
    rise = pin_s2 & ~pin_s3;
    fall = ~pin_s2 & pin_s3; // see [RQ14]
  end

  // Capture event selection
  always_comb begin
    case (ctrl.mode) // see [RQ2]
      MODE_CAP_FALL: cap_evt = fall;
      MODE_CAP_RISE: cap_evt = rise;
      MODE_CAP_RISE4: cap_evt = rise & (presc[1:0] == PRESCALE4_LAST[1:0]);
      MODE_CAP_RISE16: cap_evt = rise & (presc == PRESCALE16_LAST);
      default: cap_evt = 1'b0;
    endcase
  end

  // Compare match and PWM period events
  always_comb begin
    cmp_eq = is_cmp & ({data_high, data_low} == SIXTEEN_BIT_TIMER); // see [RQ15] [RQ21]
    cmp_evt = cmp_eq & ~cmp_eq_q;
    period_end = is_pwm & EIGHT_BIT_PERIOD_TIMER.tick
      & (EIGHT_BIT_PERIOD_TIMER.count == EIGHT_BIT_PERIOD_TIMER.limit); // see [RQ21]
    // A duty beyond the period never equals the timer, so no clear
    pwm_clear = is_pwm & ({data_high, duty_latch}
      == {EIGHT_BIT_PERIOD_TIMER.count, EIGHT_BIT_PERIOD_TIMER.sub}); // see [RQ24] [RQ26]
    next_duty = {data_low, ctrl.duty_bit_one, ctrl.duty_bit_zero}; // see [RQ6]
  end

  // Read multiplexer
  always_comb begin
    next_rdata = '0;
    if (hit_low) begin
      next_rdata[7:0] = data_low;
    end else if (hit_high) begin
      next_rdata[7:0] = data_high;
    end else if (hit_ctrl) begin
      next_rdata[7:0] = {2'b00, ctrl[5:0]};
    end else if (hit_irq) begin
      next_rdata[IRQ_FLAG_BIT] = unit_irq_flag;
      next_rdata[IRQ_ENABLE_BIT] = unit_irq_enable;
      next_rdata[OUT_LATCH_BIT] = out_latch;
    end
  end

  // APB answer: one wait state, then ready for exactly one cycle
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ready <= 1'b0;
    end else begin
      ready <= setup_wait;
    end
  end

  // Unmapped addresses answer with an error and change nothing
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      slverr <= 1'b0;
    end else begin
      slverr <= setup_wait & ~hit_any;
    end
  end

  // Read data is taken in the wait state and held until the next read
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata <= '0;
    end else if (setup_wait & ~PWRITE) begin
      rdata <= next_rdata;
    end
  end

  // Two-stage synchroniser plus one stage for edge detection
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end else begin
      pin_s1 <= UNIT_IO_PIN_IN; // see [RQ27]
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Mode control register
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl <= ccp_ctrl_t'(MODE_CONTROL_RESET);
    end else if (wr & hit_ctrl) begin
      ctrl <= ccp_ctrl_t'({2'b00, PWDATA[5:0]});
    end
  end

  // Next prescaler count, held clear outside the capture modes
  always_comb begin
    next_presc = presc;
    if (!is_cap || ctrl_off_wr) begin
      next_presc = 4'h0; // see [RQ10] [RQ1]
    end else if (rise) begin
      // Kept across changes between capture settings
      next_presc = presc + 4'h1; // see [RQ11]
    end
  end

  // Capture edge prescaler
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      presc <= 4'h0;
    end else begin
      presc <= next_presc;
    end
  end

  // Next data pair: a capture beats a software write in the same cycle
  always_comb begin
    next_data_low = data_low;
    next_data_high = data_high;
    if (cap_take) begin
      next_data_low = SIXTEEN_BIT_TIMER[7:0]; // see [RQ7] [RQ9]
      next_data_high = SIXTEEN_BIT_TIMER[15:8]; // see [RQ7] [RQ9]
    end else begin
      if (low_wr) begin
        next_data_low = PWDATA[7:0];
      end
      if (period_end) begin
        // Duty reload at the period start; the high byte is read-only here
        next_data_high = next_duty[9:2]; // see [RQ23] [RQ25]
      end else if (high_wr) begin
        next_data_high = PWDATA[7:0]; // see [RQ25]
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      data_low <= DATA_RESET;
    end else begin
      data_low <= next_data_low;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      data_high <= DATA_RESET;
    end else begin
      data_high <= next_data_high;
    end
  end

  // Next duty low bits, reloaded only at the period start
  always_comb begin
    next_duty_latch = duty_latch;
    if (ctrl_off_wr) begin
      next_duty_latch = 2'b00; // see [RQ1]
    end else if (period_end) begin
      next_duty_latch = next_duty[1:0]; // see [RQ23] [RQ25]
    end
  end

  // Internal latch of the two low duty bits
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      duty_latch <= 2'b00;
    end else begin
      duty_latch <= next_duty_latch;
    end
  end

  // Compare match memory so a held match acts once
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cmp_eq_q <= 1'b0;
    end else if (ctrl_off_wr) begin
      cmp_eq_q <= 1'b0; // see [RQ1]
    end else begin
      cmp_eq_q <= cmp_eq;
    end
  end

  // Next level of the unit output latch; the period start wins over a clear
  always_comb begin
    next_out_latch = out_latch;
    if (ctrl_off_wr) begin
      next_out_latch = 1'b0; // see [RQ1] [RQ16]
    end else if (is_cmp) begin
      if (cmp_evt & mode_set) begin
        next_out_latch = 1'b1; // see [RQ3] [RQ15]
      end else if (cmp_evt & mode_clear) begin
        next_out_latch = 1'b0; // see [RQ3] [RQ15]
      end
    end else if (is_pwm) begin
      if (period_end) begin
        next_out_latch = (next_duty != 10'h000); // see [RQ23]
      end else if (pwm_clear) begin
        next_out_latch = 1'b0; // see [RQ24]
      end
    end
  end

  // Unit output latch, separate from the port data latch
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      out_latch <= 1'b0;
    end else begin
      out_latch <= next_out_latch;
    end
  end

  // Next flag value: a hardware event beats a clear in the same cycle
  always_comb begin
    next_flag = unit_irq_flag;
    if (flag_set) begin
      next_flag = 1'b1; // see [RQ7]
    end else if (flag_clear) begin
      next_flag = 1'b0; // see [RQ8]
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      unit_irq_flag <= 1'b0;
    end else begin
      unit_irq_flag <= next_flag;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      unit_irq_enable <= 1'b0;
    end else if (irq_wr) begin
      unit_irq_enable <= PWDATA[IRQ_ENABLE_BIT];
    end
  end

  // Request to the processor only while enabled
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= unit_irq_flag & unit_irq_enable; // see [RQ4]
    end
  end

  // Trigger follows the live match; the timer resets on its next tick
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      trig <= 1'b0;
    end else begin
      trig <= next_trig;
    end
  end

  // Conversion start is one pulse in the cycle after the first cycle of a match
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      adc_go <= 1'b0;
    end else begin
      adc_go <= next_adc_go;
    end
  end

  assign PRDATA = rdata;
  assign PREADY = ready;
  assign PSLVERR = slverr;
  assign UNIT_IO_PIN_OUT = out_latch;
  assign SPECIAL_TRIGGER = trig;
  assign ADC_START = adc_go;
  assign UNIT_IRQ = irq_out;

endmodule // ccp_unit

/* File: test/ccp_unit_properties.sv */
// Port assertions for the capture/compare/PWM unit
module ccp_unit_props
  import ccp_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ccp_pkg::ADDR_W-1:0] PADDR,
  input wire logic [ccp_pkg::DATA_W-1:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic ADC_ENABLE,
  input wire logic UNIT_IO_PIN_OUT,
  input wire logic SPECIAL_TRIGGER,
  input wire logic ADC_START,
  input wire logic UNIT_IRQ
);
  logic [3:0] mode;
  logic wr;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  assign wr = PSEL && PENABLE && PREADY && PWRITE;
  // Shadow of the mode field as software last wrote it
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) mode <= 4'h0;
    else if (wr && PADDR == ADDR_MODE_CONTROL) mode <= PWDATA[3:0];
  end
  sequence s_acc;
    !PREADY ##1 PREADY;
  endsequence
  sequence s_irq_off;
    wr && PADDR == ADDR_IRQ_CONTROL && !PWDATA[IRQ_ENABLE_BIT];
  endsequence
  property p_rdy_wait;
    PSEL && $rose(PENABLE) |-> s_acc;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("access not one wait state");
  property p_rdy_pulse;
    PREADY |=> !PREADY;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
  property p_err;
    PSLVERR |-> PREADY;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_off_low;
    (mode == MODE_OFF) [*2] |-> !UNIT_IO_PIN_OUT;
  endproperty
  a_off_low: assert property (p_off_low) else $error("output high while off");
  property p_soft_pin;
    mode == MODE_CMP_SOFT && $past(mode) == MODE_CMP_SOFT |-> $stable(UNIT_IO_PIN_OUT);
  endproperty
  a_soft_pin: assert property (p_soft_pin) else $error("pin moved in flag-only mode");
  property p_trig_mode;
    SPECIAL_TRIGGER |-> $past(mode) == MODE_CMP_TRIG;
  endproperty
  a_trig_mode: assert property (p_trig_mode) else $error("trigger outside its mode");
  property p_adc_en;
    ADC_START |-> $past(ADC_ENABLE) && $past(mode) == MODE_CMP_TRIG;
  endproperty
  a_adc_en: assert property (p_adc_en) else $error("conversion start not allowed");
  property p_irq_gate;
    s_irq_off |-> ##2 !UNIT_IRQ;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request while disabled");
endmodule // ccp_unit_props

bind ccp_unit ccp_unit_props u_props (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .ADC_ENABLE(ADC_ENABLE), .UNIT_IO_PIN_OUT(UNIT_IO_PIN_OUT),
  .SPECIAL_TRIGGER(SPECIAL_TRIGGER), .ADC_START(ADC_START), .UNIT_IRQ(UNIT_IRQ));

/* File: test/ccp_partner.sv */
// Model of the two timers that feed the unit
module ccp_partner
  import ccp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic ld,
  input wire logic [15:0] ldv,
  input wire logic trig,
  input wire logic [7:0] limit,
  output logic [15:0] t16,
  output ccp_pkg::ccp_pwm_timer_t pt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] count;
  logic [1:0] sub;
  // Runs on the unit's clock, so it is always a synchronous timer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) t16 <= 16'h0000;
    else if (ld) t16 <= ldv;
    else if (run) t16 <= trig ? 16'h0000 : t16 + 16'h0001;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 8'h00;
      sub <= 2'h0;
    end else begin
      sub <= sub + 2'h1;
      if (sub == 2'h3) count <= (count == limit) ? 8'h00 : count + 8'h01;
    end
  end
  assign pt = '{count: count, sub: sub, tick: (sub == 2'h3), limit: limit};
endmodule // ccp_partner

/* File: test/ccp_unit_tb.sv */
// Self-checking bench for the capture/compare/PWM unit
module ccp_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ccp_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pin_in = 1'b0, adc_en = 1'b1, run = 1'b0, ld = 1'b0, adc_seen = 1'b0, adc_clr = 1'b0;
  logic [7:0] paddr = 8'h00, limit = 8'h09, rd, ra, rw, re;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pin_out, trig, adc_start, irq, err, rx;
  logic [15:0] t16, ldv = 16'h0, hi, h0;
  ccp_pwm_timer_t pt;
  int miscompares = 0, tests_run = 0, n;
  logic [24:0] rows [6] = '{{8'h54, 8'ha5, 8'ha5, 1'b0}, {8'h58, 8'h5a, 8'h5a, 1'b0},
    {8'h5c, 8'hff, 8'h3f, 1'b0}, {8'h5c, 8'h00, 8'h00, 1'b0}, {8'h04, 8'hff, 8'h00, 1'b1},
    {8'h60, 8'h02, 8'h02, 1'b0}};
  logic [8:0] cmp [5] = '{{8'h08, 1'b1}, {8'h0a, 1'b1}, {8'h09, 1'b0}, {8'h0b, 1'b0},
    {8'h0b, 1'b0}};
  logic [7:0] pd [5] = '{8'h01, 8'h01, 8'h02, 8'h00, 8'h20};
  logic [1:0] pb [5] = '{2'h0, 2'h2, 2'h0, 2'h0, 2'h0};
  logic [15:0] pe [5] = '{16'd0, 16'd4, 16'd8, 16'd0, 16'd80};
  always #2.5 clk = ~clk;
  always @(posedge clk) adc_seen <= adc_clr ? 1'b0 : (adc_seen | (adc_start === 1'b1));
  ccp_unit dut (.CORE_CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SIXTEEN_BIT_TIMER(t16), .EIGHT_BIT_PERIOD_TIMER(pt),
    .UNIT_IO_PIN_IN(pin_in), .ADC_ENABLE(adc_en), .UNIT_IO_PIN_OUT(pin_out),
    .SPECIAL_TRIGGER(trig), .ADC_START(adc_start), .UNIT_IRQ(irq));
  ccp_partner partner (.clk(clk), .rstn(rstn), .run(run), .ld(ld), .ldv(ldv), .trig(trig),
    .limit(limit), .t16(t16), .pt(pt));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic load(input logic [15:0] v);
    @(posedge clk);
    ld <= 1'b1;
    ldv <= v;
    @(posedge clk);
    ld <= 1'b0;
  endtask
  task automatic pulse();
    @(posedge clk);
    pin_in <= 1'b1;
    repeat (5) @(posedge clk);
    pin_in <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, ADDR_MODE_CONTROL, 8'h00);
    chk(16'(rd), 16'(MODE_CONTROL_RESET));
    for (int i = 0; i < 6; i++) begin
      {ra, rw, re, rx} = rows[i];
      apb(1'b1, ra, rw);
      apb(1'b0, ra, 8'h00);
      chk(16'(rd), 16'(re));
      chk(16'(err), 16'(rx));
    end
    for (int m = 4; m < 8; m++) begin
      n = (m == 6) ? 4 : (m == 7) ? 16 : 1;
      apb(1'b1, ADDR_MODE_CONTROL, 8'h00);
      // The pin is only ever driven from outside while capturing
      apb(1'b1, ADDR_MODE_CONTROL, 8'(m));
      apb(1'b1, ADDR_IRQ_CONTROL, 8'h03);
      for (int k = 1; k <= 2 * n; k++) begin
        load({8'(m), 8'(k)});
        pulse();
        apb(1'b0, ADDR_IRQ_CONTROL, 8'h00);
        chk(16'(rd[0]), 16'(k >= n));
      end
      apb(1'b0, ADDR_DATA_LOW, 8'h00);
      chk(16'(rd), 16'(2 * n));
      apb(1'b0, ADDR_DATA_HIGH, 8'h00);
      chk(16'(rd), 16'(m));
      chk(16'(irq), 16'h1);
    end
    run <= 1'b1;
    apb(1'b1, ADDR_MODE_CONTROL, 8'h00);
    apb(1'b1, ADDR_DATA_LOW, 8'h00);
    apb(1'b1, ADDR_DATA_HIGH, 8'h01);
    for (int i = 0; i < 5; i++) begin
      adc_en <= (i != 4);
      load(16'h00f0);
      apb(1'b1, ADDR_IRQ_CONTROL, 8'h03);
      adc_clr <= 1'b1;
      apb(1'b1, ADDR_MODE_CONTROL, cmp[i][8:1]);
      adc_clr <= 1'b0;
      repeat (40) @(posedge clk);
      chk(16'(pin_out), 16'(cmp[i][0]));
      apb(1'b0, ADDR_IRQ_CONTROL, 8'h00);
      chk(16'(rd[0]), 16'h1);
      chk(16'(adc_seen), 16'(i == 3));
      chk(16'(t16 < 16'h0100), 16'(i >= 3));
    end
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ADDR_DATA_LOW, pd[i]);
      apb(1'b1, ADDR_MODE_CONTROL, {2'b00, pb[i], 4'hc});
      repeat (50) @(posedge clk);
      apb(1'b1, ADDR_DATA_HIGH, 8'hee);
      apb(1'b0, ADDR_DATA_HIGH, 8'h00);
      chk(16'(rd), 16'(pd[i]));
      hi = 16'h0;
      repeat (80) begin
        @(posedge clk);
        hi = hi + 16'(pin_out);
      end
      if (i == 0) h0 = hi;
      chk(hi - (i < 3 ? h0 : 16'h0), pe[i]);
    end
    apb(1'b1, ADDR_MODE_CONTROL, 8'h00);
    @(posedge clk);
    chk(16'(pin_out), 16'h0);
    apb(1'b1, ADDR_IRQ_CONTROL, 8'h00);
    repeat (2) @(posedge clk);
    chk(16'(irq), 16'h0);
    complete_run();
  end
endmodule // ccp_unit_tb
